// ==== design/spv_pkg.sv ====
// Constants and types shared by the serial program/verify port
package spv_pkg;

  // Serial framing
  localparam int          CMD_BITS    = 6;
  localparam int          DATA_CYCLES = 16;
  localparam logic [3:0]  CMD_LAST    = 4'h5;
  localparam logic [3:0]  DATA_FIRST  = 4'h1;
  localparam logic [3:0]  DATA_LAST   = 4'he;
  localparam logic [3:0]  PHASE_LAST  = 4'hf;

  // Command codes, configurable per product
  localparam logic [5:0]  OP_LOAD_CFG  = 6'h01;
  localparam logic [5:0]  OP_LOAD_DATA = 6'h02;
  localparam logic [5:0]  OP_READ_DATA = 6'h03;
  localparam logic [5:0]  OP_INC_ADDR  = 6'h04;
  localparam logic [5:0]  OP_BEGIN_PGM = 6'h05;
  localparam logic [5:0]  OP_END_PGM   = 6'h06;

  // Address space
  localparam int          WORD_W      = 14;
  localparam int          PC_W        = 14;
  localparam int          USER_WORDS  = 2048;
  localparam int          USER_AW     = 11;
  localparam int          CFG_WORDS   = 8;
  localparam logic [13:0] PC_RESET    = 14'h0000;
  localparam logic [13:0] CFG_BASE    = 14'h2000;
  localparam logic [13:0] CFG_WORD_ADDR = 14'h2007;
  localparam logic [2:0]  CFG_WORD_IDX  = 3'h7;
  localparam logic [2:0]  ID_LAST_IDX   = 3'h3;
  localparam logic [10:0] USER_LAST   = 11'h7ff;
  localparam logic [10:0] CAL_ADDR    = 11'h7ff;
  localparam logic [10:0] PROT_UPPER_BASE = 11'h400;
  localparam logic [10:0] PROT_HALF_BASE  = 11'h200;

  // Blank EPROM word, also reset value of configuration space
  localparam logic [13:0] BLANK_WORD  = 14'h3fff;
  localparam logic [13:0] CFG_RESET   = 14'h3fff;

  // Configuration word fields
  localparam int          CP_A_LSB    = 12;
  localparam int          CP_B_LSB    = 10;
  localparam int          CP_C_LSB    = 8;
  localparam int          CP_D_LSB    = 5;
  localparam int          MASTER_CLEAR_PIN_SELECT_BIT   = 7;
  localparam int          POWERUP_TIMER_ENABLE_N_BIT   = 4;
  localparam int          WATCHDOG_ENABLE_BIT    = 3;
  localparam int          FOSC_LSB    = 0;

  // Code protection levels
  localparam logic [1:0]  CP_NONE     = 2'h3;
  localparam logic [1:0]  CP_UPPER    = 2'h2;
  localparam logic [1:0]  CP_HALF     = 2'h1;
  localparam logic [1:0]  CP_ALL      = 2'h0;

  // Oscillator select codes
  localparam logic [2:0]  FOSC_ERC_CLK = 3'h7;
  localparam logic [2:0]  FOSC_ERC_IO  = 3'h6;
  localparam logic [2:0]  FOSC_IRC_CLK = 3'h5;
  localparam logic [2:0]  FOSC_IRC_IO  = 3'h4;
  localparam logic [2:0]  FOSC_INVALID = 3'h3;
  localparam logic [2:0]  FOSC_HS      = 3'h2;
  localparam logic [2:0]  FOSC_XT      = 3'h1;
  localparam logic [2:0]  FOSC_LP      = 3'h0;

  typedef enum logic [2:0] {
    ST_BLANK,
    ST_OFF,
    ST_CMD,
    ST_LOAD,
    ST_READ
  } spv_state_t;

endpackage : spv_pkg

// ==== design/spv_sync.sv ====
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module spv_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : spv_sync

// ==== design/spv_port.sv ====
// Serial program/verify port with EPROM array and configuration word
`timescale 1ns/10ps
module spv_port (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        serial_clock_pin,
  input  wire logic        serial_data_in,
  input  wire logic        master_clear_pin,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  output logic             user_logic_reset,
  output logic             program_mode,
  output logic             programming_active,
  output logic [13:0]      device_configuration_word,
  output logic [1:0]       code_protect_field,
  output logic             code_protect_valid,
  output logic             master_clear_pin_select,
  output logic             powerup_timer_enable_n,
  output logic             watchdog_enable,
  output logic [2:0]       oscillator_select,
  output logic             external_rc_osc,
  output logic             internal_rc_osc,
  output logic             high_speed_crystal_osc,
  output logic             standard_crystal_osc,
  output logic             low_power_crystal_osc,
  output logic             clock_output_pin_en,
  output logic             osc_select_invalid
);

  // Pin synchronisation and edge detection
  logic [2:0]               sync_q;
  logic                     sclk_d;
  logic                     master_clear_pin_d;

  spv_sync #(
    .W (3)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({master_clear_pin, serial_clock_pin, serial_data_in}),
    .q       (sync_q)
  );

  wire master_clear_pin_s = sync_q[2];
  wire sclk_s = sync_q[1];
  wire sdat_s = sync_q[0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d <= 1'b0;
      master_clear_pin_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      master_clear_pin_d <= master_clear_pin_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  // Entry only when clock and data sit low as master clear rises
  wire mode_enter = master_clear_pin_s & ~master_clear_pin_d & ~sclk_s & ~sdat_s;
  wire mode_exit  = ~master_clear_pin_s;

  // Control state
  spv_pkg::spv_state_t      state;
  spv_pkg::spv_state_t      next_state;
  logic [3:0]               cnt;
  logic [3:0]               next_cnt;
  logic [5:0]               shift;
  logic [5:0]               next_shift;
  logic [13:0]              pc;
  logic [13:0]              next_pc;
  logic [13:0]              load_word;
  logic [13:0]              next_load_word;
  logic [13:0]              rd_buf;
  logic [13:0]              next_rd_buf;
  logic                     prog;
  logic                     next_prog;
  logic                     dout;
  logic                     next_dout;
  logic                     oe;
  logic                     next_oe;
  logic [10:0]              blank_addr;
  logic [10:0]              next_blank_addr;

  // Storage
  logic [13:0]              user_mem [0:spv_pkg::USER_WORDS-1];
  logic [13:0]              cfg_mem  [0:spv_pkg::CFG_WORDS-1];

  // Configuration word decode
  wire [13:0] cfg_word = cfg_mem[spv_pkg::CFG_WORD_IDX];
  wire [1:0]  cp_a     = cfg_word[spv_pkg::CP_A_LSB +: 2];
  wire [1:0]  cp_b     = cfg_word[spv_pkg::CP_B_LSB +: 2];
  wire [1:0]  cp_c     = cfg_word[spv_pkg::CP_C_LSB +: 2];
  wire [1:0]  cp_d     = cfg_word[spv_pkg::CP_D_LSB +: 2];
  // Mixed pairs leave the scheme disabled
  wire        cp_eq    = (cp_a == cp_b) & (cp_a == cp_c)
                       & (cp_a == cp_d);
  wire [2:0]  fosc     = cfg_word[spv_pkg::FOSC_LSB +: 3];

  // Address decode
  wire        in_cfg   = pc[13];
  wire [10:0] uaddr    = pc[10:0];
  wire [2:0]  caddr    = pc[2:0];
  // 0x2000-0x2007 live, rest of the repeating segment reserved
  wire        cfg_hit  = in_cfg & (pc[7:3] == 5'h00);
  wire        prot_all = cp_a == spv_pkg::CP_ALL;
  wire        prot_half = (cp_a == spv_pkg::CP_HALF)
                        & (uaddr >= spv_pkg::PROT_HALF_BASE);
  wire        prot_upper = (cp_a == spv_pkg::CP_UPPER)
                         & (uaddr >= spv_pkg::PROT_UPPER_BASE);
  wire        user_prot = cp_eq & ~in_cfg
                        & (uaddr != spv_pkg::CAL_ADDR)
                        & (prot_all | prot_half | prot_upper);
  wire        writable  = in_cfg ? cfg_hit : ~user_prot;
  wire [13:0] user_rd   = user_prot ? 14'h0000 : user_mem[uaddr];
  wire [13:0] cfg_rd    = cfg_hit ? cfg_mem[caddr] : spv_pkg::BLANK_WORD;
  wire [13:0] rd_word   = in_cfg ? cfg_rd : user_rd;

  // Counter wraps within its own half; top bit is sticky
  wire [13:0] pc_inc = {pc[13], 13'(pc[12:0] + 13'h0001)};
  wire [5:0]  cmd_now = {sdat_s, shift[5:1]};
  wire        in_mode = (state == spv_pkg::ST_CMD)
                      | (state == spv_pkg::ST_LOAD)
                      | (state == spv_pkg::ST_READ);
  wire        wr_en   = prog & writable & in_mode;

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_shift      = shift;
    next_pc         = pc;
    next_load_word  = load_word;
    next_rd_buf     = rd_buf;
    next_prog       = prog;
    next_dout       = dout;
    next_oe         = oe;
    next_blank_addr = blank_addr;
    case (state)
      spv_pkg::ST_BLANK: begin
        next_blank_addr = 11'(blank_addr + 11'h001);
        if (blank_addr == spv_pkg::USER_LAST) begin
          next_state = spv_pkg::ST_OFF;
        end
      end
      spv_pkg::ST_OFF: begin
        next_pc   = spv_pkg::PC_RESET;
        next_cnt  = 4'h0;
        next_prog = 1'b0;
        next_oe   = 1'b0;
        if (mode_enter) begin
          next_state = spv_pkg::ST_CMD;
        end
      end
      spv_pkg::ST_CMD: begin
        if (sclk_fall) begin
          next_shift = cmd_now;
          next_cnt   = 4'(cnt + 4'h1);
          if (cnt == spv_pkg::CMD_LAST) begin
            next_cnt = 4'h0;
            // Acts at once on the sixth falling edge
            case (cmd_now)
              spv_pkg::OP_LOAD_CFG: begin
                next_pc    = spv_pkg::CFG_BASE;
                next_state = spv_pkg::ST_LOAD;
              end
              spv_pkg::OP_LOAD_DATA: begin
                next_state = spv_pkg::ST_LOAD;
              end
              spv_pkg::OP_READ_DATA: begin
                next_rd_buf = rd_word;
                next_state  = spv_pkg::ST_READ;
              end
              spv_pkg::OP_INC_ADDR: begin
                next_pc = pc_inc;
              end
              spv_pkg::OP_BEGIN_PGM: begin
                next_prog = 1'b1;
              end
              spv_pkg::OP_END_PGM: begin
                next_prog = 1'b0;
              end
              default: begin
                next_prog = prog;
              end
            endcase
          end
        end
      end
      spv_pkg::ST_LOAD: begin
        if (sclk_fall) begin
          next_cnt = 4'(cnt + 4'h1);
          // Start bit skipped, LSB taken on second falling edge
          if (cnt >= spv_pkg::DATA_FIRST && cnt <= spv_pkg::DATA_LAST) begin
            next_load_word = {sdat_s, load_word[13:1]};
          end
          if (cnt == spv_pkg::PHASE_LAST) begin
            next_cnt   = 4'h0;
            next_state = spv_pkg::ST_CMD;
          end
        end
      end
      spv_pkg::ST_READ: begin
        if (sclk_rise) begin
          if (cnt >= spv_pkg::DATA_FIRST && cnt <= spv_pkg::DATA_LAST) begin
            next_oe     = 1'b1;
            next_dout   = rd_buf[0];
            next_rd_buf = {1'b0, rd_buf[13:1]};
          end
          if (cnt == spv_pkg::PHASE_LAST) begin
            next_oe   = 1'b0;
            next_dout = 1'b0;
          end
        end
        if (sclk_fall) begin
          next_cnt = 4'(cnt + 4'h1);
          if (cnt == spv_pkg::PHASE_LAST) begin
            next_cnt   = 4'h0;
            next_state = spv_pkg::ST_CMD;
          end
        end
      end
      default: begin
        next_state = spv_pkg::ST_OFF;
      end
    endcase
    // Dropping master clear leaves the mode from any phase
    if (mode_exit && in_mode) begin
      next_state = spv_pkg::ST_OFF;
      next_prog  = 1'b0;
      next_oe    = 1'b0;
      next_dout  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= spv_pkg::ST_BLANK;
      cnt        <= 4'h0;
      shift      <= 6'h00;
      pc         <= spv_pkg::PC_RESET;
      load_word  <= spv_pkg::BLANK_WORD;
      rd_buf     <= 14'h0000;
      prog       <= 1'b0;
      dout       <= 1'b0;
      oe         <= 1'b0;
      blank_addr <= 11'h000;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      shift      <= next_shift;
      pc         <= next_pc;
      load_word  <= next_load_word;
      rd_buf     <= next_rd_buf;
      prog       <= next_prog;
      dout       <= next_dout;
      oe         <= next_oe;
      blank_addr <= next_blank_addr;
    end
  end

  // User array: blanked after reset, then burned by AND
  always_ff @(posedge clk) begin
    if (state == spv_pkg::ST_BLANK) begin
      user_mem[blank_addr] <= spv_pkg::BLANK_WORD;
    end else if (wr_en && !in_cfg) begin
      user_mem[uaddr] <= user_mem[uaddr] & load_word;
    end
  end

  // Configuration space: burning clears bits to 0
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < spv_pkg::CFG_WORDS; i++) begin
        cfg_mem[i] <= spv_pkg::CFG_RESET;
      end
    end else if (wr_en && in_cfg) begin
      cfg_mem[caddr] <= cfg_mem[caddr] & load_word;
    end
  end

  // Held in reset while in program mode or while blanking
  wire master_clear_pin_reset = master_clear_pin_select & ~master_clear_pin_s;
  wire next_user_reset = (next_state != spv_pkg::ST_OFF) | master_clear_pin_reset
                       | (state != spv_pkg::ST_OFF);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      user_logic_reset <= 1'b1;
    end else begin
      user_logic_reset <= next_user_reset;
    end
  end

  assign serial_data_out    = dout;
  assign serial_data_oe     = oe;
  assign program_mode       = in_mode;
  assign programming_active = prog;

  assign device_configuration_word = cfg_word;
  assign code_protect_field = cp_eq ? cp_a : spv_pkg::CP_NONE;
  assign code_protect_valid = cp_eq;
  assign master_clear_pin_select = cfg_word[spv_pkg::MASTER_CLEAR_PIN_SELECT_BIT];
  assign powerup_timer_enable_n  = cfg_word[spv_pkg::POWERUP_TIMER_ENABLE_N_BIT];
  assign watchdog_enable         = cfg_word[spv_pkg::WATCHDOG_ENABLE_BIT];
  assign oscillator_select       = fosc;

  // Oscillator mode decode
  assign external_rc_osc = (fosc == spv_pkg::FOSC_ERC_CLK)
                         | (fosc == spv_pkg::FOSC_ERC_IO);
  assign internal_rc_osc = (fosc == spv_pkg::FOSC_IRC_CLK)
                         | (fosc == spv_pkg::FOSC_IRC_IO);
  assign clock_output_pin_en = (fosc == spv_pkg::FOSC_ERC_CLK)
                             | (fosc == spv_pkg::FOSC_IRC_CLK);
  assign high_speed_crystal_osc = fosc == spv_pkg::FOSC_HS;
  assign standard_crystal_osc   = fosc == spv_pkg::FOSC_XT;
  assign low_power_crystal_osc  = fosc == spv_pkg::FOSC_LP;
  assign osc_select_invalid     = fosc == spv_pkg::FOSC_INVALID;

endmodule : spv_port

// ==== verification/spv_port_properties.sv ====
// Assertions on the program/verify port outputs
`timescale 1ns/10ps
module spv_port_properties (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        master_clear_pin,
  input wire logic        serial_data_oe,
  input wire logic        user_logic_reset,
  input wire logic        program_mode,
  input wire logic        programming_active,
  input wire logic [13:0] device_configuration_word,
  input wire logic [1:0]  code_protect_field,
  input wire logic        code_protect_valid,
  input wire logic        master_clear_pin_select,
  input wire logic        powerup_timer_enable_n,
  input wire logic        watchdog_enable,
  input wire logic [2:0]  oscillator_select,
  input wire logic        external_rc_osc,
  input wire logic        internal_rc_osc,
  input wire logic        high_speed_crystal_osc,
  input wire logic        standard_crystal_osc,
  input wire logic        low_power_crystal_osc,
  input wire logic        clock_output_pin_en,
  input wire logic        osc_select_invalid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [13:0] w;
  logic [2:0]  o;
  logic        same;
  assign w = device_configuration_word;
  assign o = oscillator_select;
  assign same = w[13:12] == w[11:10] && w[11:10] == w[9:8]
                && w[9:8] == w[6:5];
  AST_HELD_RESET: assert property (program_mode |-> user_logic_reset)
    else $error("chip logic not held in reset");
  AST_OE_IN_MODE: assert property (serial_data_oe |-> program_mode)
    else $error("data pin driven outside program mode");
  AST_EXIT: assert property ($fell(master_clear_pin) |->
    ##[1:8] (!program_mode && !programming_active))
    else $error("mode not left after master clear drop");
  AST_OE_HOLD: assert property ($rose(serial_data_oe) |->
    serial_data_oe[*8])
    else $error("read drive window too short");
  AST_PGM_IN_MODE: assert property (programming_active |-> program_mode)
    else $error("programming outside program mode");
  AST_CFG_HOLD: assert property (!programming_active &&
    !$past(programming_active) |=> $stable(w))
    else $error("config word changed without programming");
  AST_CFG_CLEARS: assert property ((w & ~$past(w)) == 14'h0)
    else $error("config bit went from 0 to 1");
  AST_CP_FIELD: assert property (code_protect_valid == same &&
    code_protect_field == (same ? w[13:12] : 2'h3))
    else $error("protect field decode wrong");
  AST_PIN_SELECT: assert property (master_clear_pin_select == w[7])
    else $error("pin select decode wrong");
  AST_TIMERS: assert property (powerup_timer_enable_n == w[4] &&
    watchdog_enable == w[3])
    else $error("timer enable decode wrong");
  AST_OSC: assert property (o == w[2:0] &&
    {external_rc_osc, internal_rc_osc, high_speed_crystal_osc,
     standard_crystal_osc, low_power_crystal_osc, clock_output_pin_en,
     osc_select_invalid} == {o[2:1] == 2'h3, o[2:1] == 2'h2, o == 3'h2,
     o == 3'h1, o == 3'h0, o[2] & o[0], o == 3'h3})
    else $error("oscillator decode wrong");
endmodule : spv_port_properties

bind spv_port spv_port_properties u_props (.*);

// ==== verification/spv_programmer.sv ====
// Device programmer model driving serial clock and data
`timescale 1ns/10ps
module spv_programmer (
  output logic      serial_clock_pin,
  output logic      prog_data,
  input  wire logic data_wire
);
  initial begin
    serial_clock_pin = 1'b0;
    prog_data = 1'b0;
  end
  // Data changes after rise, sampled at fall; clock idles low
  task automatic shift(input logic [15:0] v, input int n, input bit rd,
                       output logic [15:0] got);
    got = 16'h0;
    // Keep pin edges off the system clock edges
    #2;
    for (int i = 0; i < n; i++) begin
      serial_clock_pin = 1'b1;
      prog_data = rd ? ~prog_data : v[i];
      #62.5;
      serial_clock_pin = 1'b0;
      got[i] = data_wire;
      #62.5;
    end
    prog_data = 1'b0;
    #1000;
  endtask : shift
  task automatic cmd(input logic [5:0] op);
    logic [15:0] g;
    shift({10'h0, op}, 6, 1'b0, g);
  endtask : cmd
  task automatic load(input logic [5:0] op, input logic [13:0] w);
    logic [15:0] g;
    cmd(op);
    shift({1'b0, w, 1'b0}, 16, 1'b0, g);
  endtask : load
  // Released pin carries a toggling pattern, not the last value
  task automatic read(output logic [13:0] w);
    logic [15:0] g;
    cmd(spv_pkg::OP_READ_DATA);
    shift(16'h0, 16, 1'b1, g);
    w = g[14:1];
  endtask : read
endmodule : spv_programmer

// ==== verification/spv_port_tb.sv ====
// Self-checking bench for the serial program/verify port
`timescale 1ns/10ps
module spv_port_tb;
  localparam int PULSE_NS = 1000;
  logic        clk;
  logic        sys_rst;
  logic        master_clear_pin;
  logic        serial_clock_pin;
  logic        serial_data_in;
  logic        prog_data;
  logic        serial_data_out;
  logic        serial_data_oe;
  logic        user_logic_reset;
  logic        program_mode;
  logic        programming_active;
  logic [13:0] device_configuration_word;
  logic [1:0]  code_protect_field;
  logic        code_protect_valid;
  logic        master_clear_pin_select;
  logic        powerup_timer_enable_n;
  logic        watchdog_enable;
  logic [2:0]  oscillator_select;
  logic        external_rc_osc;
  logic        internal_rc_osc;
  logic        high_speed_crystal_osc;
  logic        standard_crystal_osc;
  logic        low_power_crystal_osc;
  logic        clock_output_pin_en;
  logic        osc_select_invalid;
  logic        master_clear_pin_sel;
  int          n_mismatch;
  int          num_checks;

  assign serial_data_in = serial_data_oe ? serial_data_out : prog_data;
  spv_port u_dut (.*);
  spv_programmer u_prog (
    .serial_clock_pin (serial_clock_pin),
    .prog_data        (prog_data),
    .data_wire        (serial_data_in)
  );
  always #5 clk = ~clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait on program_mode or programming_active
  task automatic wait_for(input bit pgm, input logic v);
    int k;
    k = 0;
    while ((pgm ? programming_active : program_mode) !== v && k < 40) begin
      @(posedge clk);
      k++;
    end
    chk({15'h0, pgm ? programming_active : program_mode}, {15'h0, v});
    if (k == 40) close_out();
  endtask : wait_for
  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    master_clear_pin_sel = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2100) @(posedge clk);
  endtask : do_reset
  task automatic set_master_clear_pin(input logic v);
    @(posedge clk);
    master_clear_pin <= v;
    wait_for(1'b0, v);
    // Reset output is high with the mode, then falls one clock after it unless master clear pin select holds it
    repeat (2) @(posedge clk);
    chk({14'h0, serial_data_oe, user_logic_reset},
        {15'h0, v | master_clear_pin_sel});
  endtask : set_master_clear_pin
  task automatic pulse(input logic [13:0] w);
    u_prog.load(spv_pkg::OP_LOAD_DATA, w);
    u_prog.cmd(spv_pkg::OP_BEGIN_PGM);
    wait_for(1'b1, 1'b1);
    #(PULSE_NS);
    u_prog.cmd(spv_pkg::OP_END_PGM);
    wait_for(1'b1, 1'b0);
  endtask : pulse
  // Pulse until read back matches, then three times as many more
  task automatic burn(input logic [13:0] w);
    logic [13:0] r;
    int          n;
    n = 0;
    r = ~w;
    while (r !== w && n < 26) begin
      pulse(w);
      u_prog.read(r);
      n++;
    end
    repeat (3 * n) pulse(w);
    chk({2'h0, r}, {2'h0, w});
  endtask : burn
  task automatic s_memory();
    logic [13:0] r;
    set_master_clear_pin(1'b1);
    // The first word is read back as blank, then burned
    u_prog.read(r);
    chk({2'h0, r}, 16'h3fff);
    burn(14'h1234);
    u_prog.cmd(6'h3f);
    u_prog.read(r);
    chk({2'h0, r}, 16'h1234);
    // Second verify pass stands for the other supply level
    u_prog.read(r);
    chk({2'h0, r}, 16'h1234);
    u_prog.cmd(spv_pkg::OP_INC_ADDR);
    u_prog.read(r);
    chk({2'h0, r}, 16'h3fff);
    u_prog.load(spv_pkg::OP_LOAD_CFG, 14'h0155);
    burn(14'h0155);
    repeat (7) u_prog.cmd(spv_pkg::OP_INC_ADDR);
    burn(14'h0000);
    master_clear_pin_sel = 1'b0;
    chk({14'h0, code_protect_field}, 16'h0);
    set_master_clear_pin(1'b0);
    set_master_clear_pin(1'b1);
    u_prog.read(r);
    chk({2'h0, r}, 16'h0);
    set_master_clear_pin(1'b0);
  endtask : s_memory
  // Every oscillator code and every protect level, one reset each
  task automatic s_config();
    logic [1:0]  cp;
    logic [13:0] w;
    logic [6:0]  oe7;
    for (int i = 0; i < 8; i++) begin
      cp = 2'(i);
      w = {cp, cp, cp, i[0], cp, i[1], i[2], 3'(i)};
      oe7 = {i > 5, i == 4 || i == 5, i == 2, i == 1, i == 0,
             i == 7 || i == 5, i == 3};
      do_reset();
      chk({2'h0, device_configuration_word}, 16'h3fff);
      set_master_clear_pin(1'b1);
      u_prog.load(spv_pkg::OP_LOAD_CFG, w);
      repeat (7) u_prog.cmd(spv_pkg::OP_INC_ADDR);
      burn(w);
      master_clear_pin_sel = i[0];
      chk({2'h0, device_configuration_word}, {2'h0, w});
      chk({13'h0, code_protect_valid, code_protect_field},
          {13'h0, 1'b1, cp});
      chk({13'h0, oscillator_select}, {13'h0, 3'(i)});
      chk({15'h0, master_clear_pin_select}, {15'h0, i[0]});
      chk({14'h0, powerup_timer_enable_n, watchdog_enable},
          {14'h0, i[1], i[2]});
      chk({9'h0, external_rc_osc, internal_rc_osc, high_speed_crystal_osc,
           standard_crystal_osc, low_power_crystal_osc,
           clock_output_pin_en, osc_select_invalid}, {9'h0, oe7});
      set_master_clear_pin(1'b0);
    end
  endtask : s_config

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    master_clear_pin = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    do_reset();
    s_memory();
    s_config();
    close_out();
  end
endmodule : spv_port_tb
